/* core/vdrc_pkg.sv */
/*
 * Shared constants and types for the VLIW dispatch and register-file core.
 * Assumes it is compiled before every other design file.
 */
package vdrc_pkg;

   // ***********************************************************
   // Sizes
   // ***********************************************************
   localparam int FP_BITS  = 256;  // Fetch packet width.
   localparam int INS_BITS = 32;   // One instruction.
   localparam int NSLOT    = 8;    // Instructions per fetch packet, units.
   localparam int NREG     = 32;   // Registers per side.
   localparam int NWR      = 6;    // Write ports per register file.
   localparam logic [31:0] FP_BYTES = 32'h20;  // Fetch address step.

   // ***********************************************************
   // Instruction field positions
   // ***********************************************************
   localparam int F_CREG_HI = 31;  // Condition register select.
   localparam int F_CREG_LO = 29;
   localparam int F_Z       = 28;  // Test for zero instead of non-zero.
   localparam int F_DST_HI  = 27;
   localparam int F_DST_LO  = 23;
   localparam int F_SRC2_HI = 22;
   localparam int F_SRC2_LO = 18;
   localparam int F_SRC1_HI = 17;  // Also the short 5-bit offset.
   localparam int F_SRC1_LO = 13;
   localparam int F_X       = 12;  // Second operand over the cross path.
   localparam int F_SIZE_HI = 11;
   localparam int F_SIZE_LO = 10;
   localparam int F_CIRC    = 9;   // Circular address modification.
   localparam int F_DSIDE   = 8;   // Register file of the memory data.
   localparam int F_LOFF_HI = 22;  // Long 15-bit offset.
   localparam int F_LOFF_LO = 8;
   localparam int F_OP_HI   = 7;
   localparam int F_OP_LO   = 4;
   localparam int F_UNIT_HI = 3;   // Bit 3 is the side, 2:1 the unit kind.
   localparam int F_UNIT_LO = 1;
   localparam int F_CHAIN   = 0;   // One links the next instruction.

   // ***********************************************************
   // Enumerations
   // ***********************************************************
   typedef enum logic [3:0] {
      OP_ADD  = 4'h0, OP_SUB  = 4'h1, OP_AND  = 4'h2, OP_OR   = 4'h3,
      OP_XOR  = 4'h4, OP_ADD2 = 4'h5, OP_ADD4 = 4'h6, OP_SHL  = 4'h7,
      OP_SHR  = 4'h8, OP_MPY  = 4'h9, OP_ADDL = 4'ha, OP_MPY2 = 4'hb,
      OP_LD   = 4'hc, OP_ST   = 4'hd, OP_LDK  = 4'he, OP_STK  = 4'hf
   } vdrc_op_t;

   typedef enum logic [1:0] {
      SZ_BYTE = 2'h0, SZ_HALF = 2'h1, SZ_WORD = 2'h2, SZ_DWORD = 2'h3
   } vdrc_size_t;

   // Unit kinds: logic, shift, multiply, data-address.
   localparam int U_DAU = 3;

   typedef enum logic {
      FS_RUN  = 1'b0,   // Dispatching or about to request.
      FS_WAIT = 1'b1    // A fetch packet is outstanding.
   } vdrc_fstate_t;

endpackage

/* core/vdrc_regfile.sv */
/*
 * One side's register file: 32 registers of 32 bits, pair writes.
 * Assumes write ports never target the same register in one cycle
 * unless the higher port is meant to win.
 */
`timescale 1ns/1ps
module vdrc_regfile
   import vdrc_pkg::*;
(
   input  wire logic               clk,      // Core clock.
   input  wire logic               resetn,   // Synchronous reset, low.
   input  wire logic [NWR-1:0]     wr_en,    // Write enables.
   input  wire logic [NWR-1:0]     wr_pair,  // Write the even/odd pair.
   input  wire logic [NWR*5-1:0]   wr_idx,   // Destination indices.
   input  wire logic [NWR*64-1:0]  wr_data,  // Pair data, low word first.
   output logic [NREG*32-1:0]      regs,     // All registers, flat.
   output logic [NREG-1:0]         wr_mask   // Written at the last edge.
);

   logic [NREG-1:0] next_mask;  // Registers touched this cycle.

   // Mask of every register that a port writes now.
   always_comb
   begin
      next_mask = '0;
      for (int p = 0; p < NWR; p++)
      begin
         if (wr_en[p] && wr_pair[p])
         begin
            next_mask[{wr_idx[p*5+1 +: 4], 1'b0}] = 1'b1;
            next_mask[{wr_idx[p*5+1 +: 4], 1'b1}] = 1'b1;
         end
         else if (wr_en[p])
            next_mask[wr_idx[p*5 +: 5]] = 1'b1;
      end
   end

   // Storage; a pair write always lands on an even/odd pair.
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         regs    <= '0;
         wr_mask <= '0;
      end
      else
      begin
         wr_mask <= next_mask;
         for (int p = 0; p < NWR; p++)
         begin
            if (wr_en[p] && wr_pair[p])
               regs[{wr_idx[p*5+1 +: 4], 1'b0}*32 +: 32] <= wr_data[p*64 +: 32];
            else if (wr_en[p])
               regs[wr_idx[p*5 +: 5]*32 +: 32] <= wr_data[p*64 +: 32];
            if (wr_en[p] && wr_pair[p])
               regs[{wr_idx[p*5+1 +: 4], 1'b1}*32 +: 32] <= wr_data[p*64+32 +: 32];
         end
      end
   end

endmodule // vdrc_regfile

/* core/vdrc_core.sv */
/*
 * Dispatch, execute and register files of an eight-unit VLIW core.
 * Assumes program and data memory on the same clock; data memory handles
 * non-aligned addresses and returns load data right-justified.
 */
`timescale 1ns/1ps

module vdrc_core
   import vdrc_pkg::*;
#(
   parameter logic [31:0] RESET_PC    = 32'h0,           // First fetch address.
   parameter logic [47:0] COND_MAP    = 48'h1c61440c2040, // {side,idx} per code.
   parameter logic [2:0]  ALWAYS_CREG = 3'h0,            // Always-true code.
   parameter logic [4:0]  LONG_BASE   = 5'h0f,           // Long-offset base.
   parameter int          CIRC_LOG2   = 8                // Log2 of circular block bytes.
)
(
   input  wire logic         clk,          // Core clock, 100 MHz.
   input  wire logic         resetn,       // Synchronous reset, low.
   output logic              fetch_req,    // One-cycle fetch request.
   output logic [31:0]       fetch_addr,   // Fetch packet byte address.
   input  wire logic         fetch_valid,  // Fetch packet returned.
   input  wire logic [255:0] fetch_data,   // Fetch packet, slot 0 low.
   output logic [7:0]        issue_valid,  // Unit received an instruction.
   output logic [255:0]      issue_instr,  // Instruction per unit.
   output logic              xpath_stall,  // Cross-path stall cycle.
   output logic [1:0]        dmem_req,     // Data request per side.
   output logic [1:0]        dmem_we,      // Request is a store.
   output logic [63:0]       dmem_addr,    // Byte addresses.
   output logic [3:0]        dmem_size,    // Transfer sizes.
   output logic [127:0]      dmem_wdata,   // Store data, right-justified.
   input  wire logic [1:0]   dmem_rvalid,  // Load data returned.
   input  wire logic [127:0] dmem_rdata    // Load data, right-justified.
);

   // ***********************************************************
   // Checks and helpers
   // ***********************************************************
   if (CIRC_LOG2 < 1 || CIRC_LOG2 > 31)
   begin : g_chk
      $error("CIRC_LOG2 must lie between 1 and 31");
   end

   localparam logic [31:0] CMASK = (32'h1 << CIRC_LOG2) - 32'h1;

   logic [NREG*32-1:0] rf_a, rf_b;   // Register file contents.
   logic [NREG-1:0]    wm_a, wm_b;   // Written at the last edge.

   // Same-side and cross reads are plain selects, so all units are
   // served in one cycle.
   // The files are arguments, so continuous assignments that call this
   // re-evaluate whenever a register changes, not only when the index does.
   function automatic logic [31:0] rd(input logic s, input logic [4:0] i,
                                      input logic [NREG*32-1:0] fa,
                                      input logic [NREG*32-1:0] fb);
      rd = s ? fb[i*32 +: 32] : fa[i*32 +: 32];
   endfunction

   // Shared arithmetic for every unit; bit 64 asks for a pair write.
   function automatic logic [64:0] alu(input logic [3:0] op,
                                       input logic [31:0] a,
                                       input logic [31:0] b);
      logic [63:0] r;
      logic        pr;
      r  = '0;
      pr = 1'b0;
      case (op)
         OP_ADD:  r[31:0] = a + b;
         OP_SUB:  r[31:0] = a - b;
         OP_AND:  r[31:0] = a & b;
         OP_OR:   r[31:0] = a | b;
         OP_XOR:  r[31:0] = a ^ b;
         OP_ADD2: r[31:0] = {a[31:16] + b[31:16], a[15:0] + b[15:0]};
         OP_ADD4:
            for (int k = 0; k < 4; k++)
               r[k*8 +: 8] = a[k*8 +: 8] + b[k*8 +: 8];
         OP_SHL:  r[31:0] = a << b[4:0];
         OP_SHR:  r[31:0] = 32'($signed(a) >>> b[4:0]);
         OP_MPY:
         begin
            r  = 64'($signed({{32{a[31]}}, a}) * $signed({{32{b[31]}}, b}));
            pr = 1'b1;
         end
         OP_ADDL:
         begin
            r[39:0] = {{8{a[31]}}, a} + {{8{b[31]}}, b};
            pr      = 1'b1;
         end
         OP_MPY2:
         begin
            r  = {32'($signed(a[31:16]) * $signed(b[31:16])),
                  32'($signed(a[15:0]) * $signed(b[15:0]))};
            pr = 1'b1;
         end
         default: r = '0;
      endcase
      alu = {pr, r};
   endfunction

   // Load data extension by size; a doubleword fills a pair.
   function automatic logic [64:0] ld_ext(input logic [1:0] sz,
                                          input logic [63:0] d);
      case (sz)
         SZ_BYTE: ld_ext = {1'b0, 32'h0, {24{d[7]}}, d[7:0]};
         SZ_HALF: ld_ext = {1'b0, 32'h0, {16{d[15]}}, d[15:0]};
         SZ_WORD: ld_ext = {1'b0, 32'h0, d[31:0]};
         default: ld_ext = {1'b1, d};
      endcase
   endfunction

   // ***********************************************************
   // Instruction window and packet scan
   // ***********************************************************
   logic [511:0]  win;       // Current fetch packet low, next high.
   logic [4:0]    nv;        // Loaded slots: 0, 8 or 16.
   logic [3:0]    ptr;       // Next slot to dispatch in the low packet.
   vdrc_fstate_t  fs;        // Fetch state.
   logic          stalled;   // A stall cycle was just spent.
   logic          found;     // A complete execute packet is visible.
   logic [2:0]    plen;      // Packet length minus one.
   logic [4:0]    pos;       // Scan position.

   // Walk from ptr until a chain bit of zero, crossing into the next
   // packet if it is loaded, so no padding is needed.
   always_comb
   begin
      found = 1'b0;
      plen  = 3'h0;
      pos   = 5'h0;
      for (int j = 0; j < NSLOT; j++)
      begin
         pos = 5'(ptr) + 5'(j);
         if (!found && pos < nv)
         begin
            plen = 3'(j);
            // Eight linked instructions close the packet regardless.
            if (!win[pos*32 + F_CHAIN] || j == NSLOT - 1)
               found = 1'b1;
         end
      end
   end

   // ***********************************************************
   // Routing to units
   // ***********************************************************
   logic [7:0]   slot_v;   // Unit has an instruction in this packet.
   logic [255:0] slot_i;   // Instruction per unit.
   logic [31:0]  pi;       // Packet instruction under routing.

   // Each instruction goes to the unit its unit field names; units not
   // named stay empty.
   always_comb
   begin
      slot_v = '0;
      slot_i = '0;
      pi     = '0;
      for (int j = 0; j < NSLOT; j++)
      begin
         pi = win[(5'(ptr) + 5'(j))*32 +: 32];
         if (found && 3'(j) <= plen)
         begin
            slot_v[pi[F_UNIT_HI:F_UNIT_LO]]         = 1'b1;
            slot_i[pi[F_UNIT_HI:F_UNIT_LO]*32 +: 32] = pi;
         end
      end
   end

   // ***********************************************************
   // Cross path and stall
   // ***********************************************************
   logic [1:0]  xneed;    // Some unit on the side reads across.
   logic [4:0]  xsel[2];  // Register driven onto each cross bus.
   logic [31:0] xbus[2];  // Cross bus value per side.
   logic [1:0]  hazard;   // Cross register written last cycle.
   wire         need_stall = found && (|hazard) && !stalled;
   wire         issue      = found && !need_stall;

   // One bus per side; the lowest unit using it picks the register and
   // the others share that value.
   always_comb
   begin
      for (int s = 0; s < 2; s++)
      begin
         xneed[s] = 1'b0;
         xsel[s]  = 5'h0;
         for (int k = 3; k >= 0; k--)
         begin
            if (slot_v[s*4+k] && slot_i[(s*4+k)*32 + F_X])
            begin
               xneed[s] = 1'b1;
               xsel[s]  = slot_i[(s*4+k)*32 + F_SRC2_LO +: 5];
            end
         end
         xbus[s]   = rd(s == 0, xsel[s], rf_a, rf_b);
         hazard[s] = xneed[s] && (s == 0 ? wm_b[xsel[s]] : wm_a[xsel[s]]);
      end
   end

   // ***********************************************************
   // Units
   // ***********************************************************
   logic [7:0]   uwen, upair;  // Unit result writes.
   logic [4:0]   udst[8];      // Unit destinations.
   logic [63:0]  ures[8];      // Unit results.
   logic [1:0]   mreq, mwe, mds;
   logic [63:0]  maddr;
   logic [3:0]   msize;
   logic [127:0] mwdata;
   logic [4:0]   mdst[2];

   for (genvar u = 0; u < NSLOT; u++)
   begin : g_unit
      localparam logic S = (u >= 4);
      wire [31:0] ins  = slot_i[u*32 +: 32];
      wire [4:0]  src1 = ins[F_SRC1_HI:F_SRC1_LO];
      wire [4:0]  src2 = ins[F_SRC2_HI:F_SRC2_LO];
      wire [3:0]  op   = ins[F_OP_HI:F_OP_LO];
      wire [2:0]  creg = ins[F_CREG_HI:F_CREG_LO];
      wire [5:0]  cm   = COND_MAP[creg*6 +: 6];
      wire [31:0] opb  = ins[F_X] ? xbus[S] : rd(S, src2, rf_a, rf_b);
      wire [64:0] ar   = alu(op, rd(S, src1, rf_a, rf_b), opb);
      // The always code runs unconditionally; others test a register.
      wire        c_ok = (creg == ALWAYS_CREG) || ((rd(cm[5], cm[4:0], rf_a, rf_b) != 32'h0) ^ ins[F_Z]);
      wire        go   = slot_v[u] && issue && c_ok;
      assign uwen[u]  = go && (op < OP_LD);   // Arithmetic writes registers only.
      assign upair[u] = ar[64];
      assign ures[u]  = ar[63:0];
      assign udst[u]  = ins[F_DST_HI:F_DST_LO];

      if ((u % 4) == U_DAU)
      begin : g_dau
         wire        lng  = (op == OP_LDK) || (op == OP_STK);
         wire [1:0]  sz   = lng ? SZ_WORD : ins[F_SIZE_HI:F_SIZE_LO];
         wire [31:0] base = rd(S, lng ? LONG_BASE : src2, rf_a, rf_b);
         // Offsets scale by the access size.
         wire [31:0] off  = lng ? {17'h0, ins[F_LOFF_HI:F_LOFF_LO]} << sz : {27'h0, src1} << sz;
         wire [31:0] lin  = base + off;
         wire [31:0] cir  = (base & ~CMASK) | (lin & CMASK);
         wire        ds   = lng ? S : ins[F_DSIDE];
         wire [4:0]  dev  = {ins[F_DST_HI:F_DST_LO+1], 1'b0};
         wire        dw   = (sz == SZ_DWORD);
         assign mreq[S]  = go && (op >= OP_LD);
         assign mwe[S]   = (op == OP_ST) || (op == OP_STK);
         // Any byte address is passed through unaligned.
         assign maddr[S*32 +: 32] = (ins[F_CIRC] && !lng) ? cir : lin;
         assign msize[S*2 +: 2]   = sz;
         // Store data may come from the other side's file.
         assign mwdata[S*64 +: 64] = dw ? {rd(ds, dev | 5'h1, rf_a, rf_b), rd(ds, dev, rf_a, rf_b)}
                                        : {32'h0, rd(ds, udst[u], rf_a, rf_b)};
         assign mds[S]  = ds;
         assign mdst[S] = udst[u];
      end
   end

   // ***********************************************************
   // Loads outstanding and register-file ports
   // ***********************************************************
   logic [1:0] pd_side;        // Destination file of each pending load.
   logic [4:0] pd_dst[2];      // Destination register.
   logic [3:0] pd_size;        // Load size.
   logic [NWR-1:0]    wa_en, wb_en, wa_pr, wb_pr;
   logic [NWR*5-1:0]  wa_ix, wb_ix;
   logic [NWR*64-1:0] wa_d, wb_d;

   // Ports 0..3 take own-side unit results, ports 4..5 load returns,
   // so a returning load wins a clash with a unit write.
   always_comb
   begin
      for (int k = 0; k < 4; k++)
      begin
         wa_en[k] = uwen[k];
         wa_pr[k] = upair[k];
         wa_ix[k*5 +: 5] = udst[k];
         wa_d[k*64 +: 64] = ures[k];
         wb_en[k] = uwen[k+4];
         wb_pr[k] = upair[k+4];
         wb_ix[k*5 +: 5] = udst[k+4];
         wb_d[k*64 +: 64] = ures[k+4];
      end
      for (int d = 0; d < 2; d++)
      begin
         wa_en[4+d] = dmem_rvalid[d] && !pd_side[d];
         wb_en[4+d] = dmem_rvalid[d] && pd_side[d];
         {wa_pr[4+d], wa_d[(4+d)*64 +: 64]} = ld_ext(pd_size[d*2 +: 2], dmem_rdata[d*64 +: 64]);
         {wb_pr[4+d], wb_d[(4+d)*64 +: 64]} = ld_ext(pd_size[d*2 +: 2], dmem_rdata[d*64 +: 64]);
         wa_ix[(4+d)*5 +: 5] = pd_dst[d];
         wb_ix[(4+d)*5 +: 5] = pd_dst[d];
      end
   end

   // Two files of 32 registers each.
   vdrc_regfile u_rf_a (
      .clk     (clk),
      .resetn  (resetn),
      .wr_en   (wa_en),
      .wr_pair (wa_pr),
      .wr_idx  (wa_ix),
      .wr_data (wa_d),
      .regs    (rf_a),
      .wr_mask (wm_a)
   );

   vdrc_regfile u_rf_b (
      .clk     (clk),
      .resetn  (resetn),
      .wr_en   (wb_en),
      .wr_pair (wb_pr),
      .wr_idx  (wb_ix),
      .wr_data (wb_d),
      .regs    (rf_b),
      .wr_mask (wm_b)
   );

   // ***********************************************************
   // Fetch and dispatch sequencing
   // ***********************************************************
   wire [3:0] np         = ptr + 4'(plen) + 4'h1;
   wire       need_fetch = (fs == FS_RUN) && !found && (nv < 5'h10);

   // Next packet is fetched only when nothing complete is left, so the
   // current one drains first.
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         win        <= '0;
         nv         <= 5'h0;
         ptr        <= 4'h0;
         fs         <= FS_RUN;
         fetch_req  <= 1'b0;
         fetch_addr <= RESET_PC;
      end
      else
      begin
         fetch_req <= need_fetch;
         if (need_fetch)
            fs <= FS_WAIT;
         else if (fs == FS_WAIT && fetch_valid)
         begin
            fs         <= FS_RUN;
            fetch_addr <= fetch_addr + FP_BYTES;
            nv         <= nv + 5'h8;
            if (nv == 5'h0)
               win[255:0] <= fetch_data;
            else
               win[511:256] <= fetch_data;
         end
         else if (issue && np >= 4'h8)
         begin
            // Whole low packet used: the next one slides down.
            win <= {256'h0, win[511:256]};
            nv  <= nv - 5'h8;
            ptr <= np - 4'h8;
         end
         else if (issue)
            ptr <= np;
      end
   end

   // Registered issue view, stall flag and memory requests.
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         issue_valid <= '0;
         issue_instr <= '0;
         xpath_stall <= 1'b0;
         stalled     <= 1'b0;
         dmem_req    <= '0;
         dmem_we     <= '0;
         dmem_addr   <= '0;
         dmem_size   <= '0;
         dmem_wdata  <= '0;
      end
      else
      begin
         issue_valid <= issue ? slot_v : 8'h0;
         issue_instr <= issue ? slot_i : 256'h0;
         xpath_stall <= need_stall;
         stalled     <= need_stall;
         dmem_req    <= mreq;
         dmem_we     <= mreq & mwe;
         dmem_addr   <= maddr;
         dmem_size   <= msize;
         dmem_wdata  <= mwdata;
      end
   end

   // Destination of each side's latest load, used when data returns.
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         pd_side <= '0;
         pd_size <= '0;
         pd_dst  <= '{default: 5'h0};
      end
      else
      begin
         for (int d = 0; d < 2; d++)
         begin
            if (mreq[d] && !mwe[d])
            begin
               pd_side[d]         <= mds[d];
               pd_size[d*2 +: 2]  <= msize[d*2 +: 2];
               pd_dst[d]          <= mdst[d];
            end
         end
      end
   end

endmodule // vdrc_core

/* dv/vdrc_mem_model.sv */
/* Program and data memory model for the core.
   Assumes the bench sets prog at time zero. */
`timescale 1ns/1ps
module vdrc_mem_model
(
   input  wire logic         clk,          // Core clock.
   input  wire logic         resetn,       // Reset, low.
   input  wire logic [511:0] prog,         // Two fetch packets from 0x0.
   input  wire logic         fetch_req,    // Fetch request.
   input  wire logic [31:0]  fetch_addr,   // Fetch address.
   output logic              fetch_valid,  // Packet returned.
   output logic [255:0]      fetch_data,   // Packet.
   input  wire logic [1:0]   dmem_req,     // Data requests.
   input  wire logic [1:0]   dmem_we,      // Stores.
   input  wire logic [63:0]  dmem_addr,    // Addresses.
   output logic [1:0]        dmem_rvalid,  // Load answers.
   output logic [127:0]      dmem_rdata    // Load data.
);
   // Answers come one cycle after a request; between answers the buses toggle so stale data is never reused.
   always_ff @(posedge clk)
   begin
      fetch_valid <= fetch_req & resetn;
      fetch_data  <= !resetn ? 256'h0 : !fetch_req ? ~fetch_data :
                     (fetch_addr < 32'h40 ? prog[fetch_addr[5]*256 +: 256] : 256'h0);
      dmem_rvalid <= dmem_req & ~dmem_we & {2{resetn}};
      dmem_rdata  <= !resetn ? 128'h0 : dmem_req != 2'h0 ? {2{dmem_addr}} : ~dmem_rdata;
   end
endmodule // vdrc_mem_model

/* dv/vdrc_core_sva.sv */
/* Port checker for the core.
   Assumes a single clock and synchronous reset. */
`timescale 1ns/1ps
module vdrc_core_sva
   import vdrc_pkg::*;
#(parameter logic [31:0] RESET_PC = 32'h0)  // First fetch address.
(
   input wire logic         clk,          // Clock.
   input wire logic         resetn,       // Reset, low.
   input wire logic         fetch_req,    // Fetch request.
   input wire logic [31:0]  fetch_addr,   // Fetch address.
   input wire logic         fetch_valid,  // Packet returned.
   input wire logic [7:0]   issue_valid,  // Units issued.
   input wire logic [255:0] issue_instr,  // Issued words.
   input wire logic         xpath_stall,  // Stall cycle.
   input wire logic [1:0]   dmem_req      // Data requests.
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   // A stall cycle issues nothing, then the held packet goes out.
   sequence stall_gap;
      issue_valid == 8'h0 ##1 issue_valid != 8'h0;
   endsequence
   fetch_pulse_a: assert property (fetch_req |=> !fetch_req) else $error("fetch request too long");
   reset_state_a: assert property ($rose(resetn) |-> (fetch_addr == RESET_PC && issue_valid == 8'h0) ##1 fetch_req)
      else $error("bad state after reset");
   fetch_step_a: assert property (fetch_valid |=> fetch_addr == $past(fetch_addr) + FP_BYTES)
      else $error("fetch address did not step");
   first_issue_a: assert property (fetch_valid |-> ##2 (issue_valid != 8'h0 || xpath_stall))
      else $error("no dispatch after fetch");
   stall_once_a: assert property (xpath_stall |=> !xpath_stall) else $error("two stalls in a row");
   stall_hold_a: assert property (xpath_stall |-> stall_gap) else $error("stall did not hold packet");
   dau_only_a: assert property ((dmem_req & ~{issue_valid[7], issue_valid[3]}) == 2'h0)
      else $error("memory access from non data unit");
   for (genvar k = 0; k < 8; k++)
   begin : g_idle
      idle_zero_a: assert property (!issue_valid[k] |-> issue_instr[k*32 +: 32] == 32'h0)
         else $error("idle unit shows an instruction");
   end
endmodule // vdrc_core_sva
bind vdrc_core vdrc_core_sva #(.RESET_PC(RESET_PC)) vdrc_core_sva_i (.clk, .resetn, .fetch_req, .fetch_addr,
   .fetch_valid, .issue_valid, .issue_instr, .xpath_stall, .dmem_req);

/* dv/testbench.sv */
/* Self-checking bench for the core.
   Assumes the memory model answers and the checker is bound. */
`timescale 1ns/1ps
module testbench;
   import vdrc_pkg::*;
   logic         clk, resetn, fetch_req, fetch_valid, xpath_stall;  // Control.
   logic [31:0]  fetch_addr;                                        // Fetch address.
   logic [255:0] fetch_data, issue_instr, ei [8];                   // Packets.
   logic [7:0]   issue_valid, em [8];                               // Unit masks.
   logic [1:0]   dmem_req, dmem_we, dmem_rvalid;                    // Data control.
   logic [63:0]  dmem_addr;                                         // Data address.
   logic [3:0]   dmem_size;                                         // Data size.
   logic [127:0] dmem_wdata, dmem_rdata;                            // Data.
   logic [511:0] prog;                                              // Program.
   logic [255:0] gi [$];                                            // Seen words.
   logic [7:0]   gm [$];                                            // Seen masks.
   logic [31:0]  fa [$];                                            // Seen fetches.
   int           err_count, check_count, stalls, loads;             // Counters.
   vdrc_core vdrc_core_i (.clk, .resetn, .fetch_req, .fetch_addr, .fetch_valid, .fetch_data, .issue_valid,
      .issue_instr, .xpath_stall, .dmem_req, .dmem_we, .dmem_addr, .dmem_size, .dmem_wdata, .dmem_rvalid, .dmem_rdata);
   vdrc_mem_model vdrc_mem_model_i (.clk, .resetn, .prog, .fetch_req, .fetch_addr, .fetch_valid, .fetch_data,
      .dmem_req, .dmem_we, .dmem_addr, .dmem_rvalid, .dmem_rdata);
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Record pre-edge outputs so sampling never races the flops.
   always @(posedge clk)
   begin
      if (resetn && issue_valid != 8'h0)
      begin
         gm.push_back(issue_valid);
         gi.push_back(issue_instr);
      end
      if (resetn && fetch_req) fa.push_back(fetch_addr);
      stalls += resetn && xpath_stall;
      loads += resetn && dmem_req[0];
   end
   function automatic logic [31:0] ins(input int u, op, d, s, x, c);
      return {4'h0, d[4:0], s[4:0], 5'h0, x[0], 4'h0, op[3:0], u[2:0], c[0]};
   endfunction
   task automatic check(input logic [255:0] seen, exp);
      check_count++;
      if (seen !== exp)
      begin
         err_count++;
         $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   task automatic finish_test;
      if (err_count == 0 && check_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // Reset for five cycles, then run until eight packets are out.
   task automatic run_prog;
      resetn <= 1'b0;
      repeat (5) @(posedge clk);
      gm.delete();
      gi.delete();
      fa.delete();
      stalls = 0;
      loads = 0;
      resetn <= 1'b1;
      for (int n = 0; n < 200 && gm.size() < 8; n++) @(posedge clk);
   endtask
   // Packets split on the chain bit, including the one across a fetch boundary.
   task automatic check_dispatch;
      int          e;
      logic [31:0] w;
      e = 0;
      for (int i = 0; i < 8; i++)
      begin
         em[i] = 8'h0;
         ei[i] = 256'h0;
      end
      for (int i = 0; i < 24 && e < 8; i++)
      begin
         w = i < 16 ? prog[i*32 +: 32] : 32'h0;
         em[e][w[3:1]] = 1'b1;
         ei[e][w[3:1]*32 +: 32] = w;
         if (!w[0]) e++;
      end
      for (int i = 0; i < 8; i++)
      begin
         check(gm[i], em[i]);
         check(gi[i], ei[i]);
      end
   endtask
   // One cross-path stall, one load, fetches strictly in steps.
   task automatic check_side;
      check(stalls, 1);
      check(loads, 1);
      for (int i = 0; i < 3; i++) check(fa[i], i * FP_BYTES);
   endtask
   initial
   begin
      resetn = 1'b0;
      err_count = 0;
      check_count = 0;
      prog[255:0] = {ins(2, 9, 6, 0, 0, 1), ins(7, 0, 5, 0, 0, 1), ins(6, 0, 5, 0, 0, 0), ins(5, 0, 5, 0, 0, 0),
                     ins(3, 12, 4, 0, 0, 0), ins(4, 0, 3, 1, 1, 0), ins(1, 7, 2, 0, 0, 0), ins(0, 0, 1, 0, 0, 1)};
      for (int k = 1; k < 8; k++) prog[256+k*32 +: 32] = ins(k, 0, 8 + k, 0, 0, k < 7);
      prog[287:256] = ins(0, 0, 9, 0, 0, 0);
      repeat (2)
      begin
         run_prog;
         check_dispatch;
         check_side;
      end
      finish_test;
   end
   // Cut a hang short well past both runs.
   initial
   begin
      repeat (1000) @(posedge clk);
      err_count++;
      finish_test;
   end
endmodule // testbench
